// ### design/ssom_defs.svh
// constants of the safety output monitor: codes, timing and reset values
`ifndef SSOM_DEFS_SVH
`define SSOM_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SSOM_CLOCK_MHZ 125
`define SSOM_TICK_US 1000
`define SSOM_TICK_CYC (`SSOM_TICK_US * `SSOM_CLOCK_MHZ)
`define SSOM_IDLE_FBK_MS 16'h2710
`define SSOM_LAMP_HALF_MS 16'h00FA
`define SSOM_MS_MAX 16'hFFFF

// ----------------------------------------
// relay categories and channel layouts
// ----------------------------------------
`define SSOM_CAT_1 2'h1
`define SSOM_CAT_2 2'h2
`define SSOM_CAT_4 2'h3
`define SSOM_LAYOUT_FOUR_SINGLE 2'h0
`define SSOM_LAYOUT_TWO_DOUBLE 2'h1
`define SSOM_LAYOUT_MIXED 2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SSOM_RST_BIT 1'h0
`define SSOM_RST_MS 16'h0000

`endif

// ### design/ssom_ms_tick.sv
// one millisecond tick divided down from the system clock
`timescale 1ns/10ps
`include "ssom_defs.svh"
module ssom_ms_tick #(
    parameter int MS_CYCLES = `SSOM_TICK_CYC
) (
    input wire logic clock,
    input wire logic srst,
    output logic tick
);
    // ----------------------------------------
    // divider
    // ----------------------------------------
    localparam int CW = $clog2(MS_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(MS_CYCLES - 1);
    logic [CW-1:0] div_reg;
    logic tick_reg;
    wire div_wrap = (div_reg == LAST);

    generate
        if (MS_CYCLES < 2) begin : g_bad
            $error("ssom_ms_tick: MS_CYCLES must be at least 2");
        end
    endgenerate

    // count cycles, pulse once per wrap
    always_ff @(posedge clock) begin
        if (srst) begin
            div_reg <= '0;
            tick_reg <= `SSOM_RST_BIT;
        end else begin
            div_reg <= div_wrap ? '0 : div_reg + 1'b1;
            tick_reg <= div_wrap;
        end
    end
    assign tick = tick_reg;
endmodule

// ### design/ssom_pkg.sv
// types of the safety output monitor
package ssom_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT_RESET,
        ST_ON
    } ssom_state_t;
    typedef logic [15:0] ssom_ms_t;
endpackage

// ### design/ssom_reset_detect.sv
// accepts a reset request as a rising edge or as a complete high pulse
`timescale 1ns/10ps
`include "ssom_defs.svh"
module ssom_reset_detect (
    input wire logic clock,
    input wire logic srst,
    input wire logic req_level,
    input wire logic monitored,
    output logic accept
);
    // ----------------------------------------
    // edge tracking
    // ----------------------------------------
    logic prev_reg;
    logic seen_high_reg;
    logic accept_reg;
    wire rise_w = req_level && !prev_reg;
    wire fall_w = !req_level && prev_reg;
    // monitored needs 0-1-0, manual only 0-1
    wire accept_next = monitored ? (fall_w && seen_high_reg) : rise_w;

    // remember a rise until the matching fall
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_reg <= `SSOM_RST_BIT;
            seen_high_reg <= `SSOM_RST_BIT;
            accept_reg <= `SSOM_RST_BIT;
        end else begin
            prev_reg <= req_level;
            seen_high_reg <= rise_w ? 1'b1 : (fall_w ? 1'b0 : seen_high_reg);
            accept_reg <= accept_next;
        end
    end
    assign accept = accept_reg;
endmodule

// ### design/ssom_top.sv
// safety output function block: restart, contactor feedback check, indicators
`timescale 1ns/10ps
`include "ssom_defs.svh"
module ssom_top
    import ssom_pkg::*;
#(
    parameter int MS_CYCLES = `SSOM_TICK_CYC,
    parameter int BLOCK_INDEX = 0
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic block_in,
    input wire logic reset_pin,
    input wire logic feedback_pin,
    input wire logic global_reset_operator,
    input wire logic low_int_in,
    input wire logic cfg_manual_restart,
    input wire logic cfg_monitored_reset,
    input wire logic cfg_fbk_monitor,
    input wire logic [15:0] cfg_fbk_window_ms,
    input wire logic cfg_error_out_en,
    input wire logic cfg_status_en,
    input wire logic cfg_no_test_pulse,
    input wire logic cfg_fbk_unconnected,
    input wire logic cfg_is_relay,
    input wire logic [1:0] cfg_relay_cat,
    input wire logic [1:0] cfg_layout,
    output logic output_channel_a,
    output logic output_channel_b,
    output logic relay_contact_a,
    output logic relay_contact_b,
    output logic error_out,
    output logic clear_indicator_lamp,
    output logic status_out,
    output logic output_test_indicator,
    output logic test_pulse_en,
    output logic safety_lost,
    output logic restart_feedback_exposed,
    output logic low_int_status_out,
    output logic config_fault
);
    // ----------------------------------------
    // parameter checks and layout decoding
    // ----------------------------------------
    generate
        if (BLOCK_INDEX < 0 || BLOCK_INDEX > 3) begin : g_bad_index
            $error("ssom_top: BLOCK_INDEX must be 0 to 3");
        end
        if (MS_CYCLES < 2) begin : g_bad_ms
            $error("ssom_top: MS_CYCLES must be at least 2");
        end
    endgenerate

    localparam logic [1:0] IDX = 2'(BLOCK_INDEX);

    // block slot in use for a layout, and whether it drives a pair
    function automatic logic [1:0] layout_slot(input logic [1:0] lay, input logic [1:0] idx);
        logic [1:0] r;
        r = 2'h0;
        case (lay)
            `SSOM_LAYOUT_FOUR_SINGLE: r = 2'h1;
            `SSOM_LAYOUT_TWO_DOUBLE: r = (idx < 2'h2) ? 2'h3 : 2'h0;
            `SSOM_LAYOUT_MIXED: r = (idx < 2'h2) ? 2'h1 : ((idx == 2'h2) ? 2'h3 : 2'h0);
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    wire [1:0] slot_w = layout_slot(cfg_layout, IDX);
    wire present_w = slot_w[0];
    wire double_w = slot_w[1];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    wire [1:0] pin_raw_w = {reset_pin, feedback_pin};

    // two flops per pin, first stage read only by the second
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (srst) begin
                    pin_meta_reg[gi] <= `SSOM_RST_BIT;
                    pin_sync_reg[gi] <= `SSOM_RST_BIT;
                end else begin
                    pin_meta_reg[gi] <= pin_raw_w[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    // synchronised levels, bit 1 is the pushbutton
    wire reset_level_w = pin_sync_reg[1];
    wire fbk_w = pin_sync_reg[0];

    // ----------------------------------------
    // helpers: millisecond tick and reset acceptance
    // ----------------------------------------
    logic ms_tick;
    logic reset_accept;

    ssom_ms_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) i_ssom_ms_tick (
        .clock(clock),
        .srst(srst),
        .tick(ms_tick)
    );

    ssom_reset_detect i_ssom_reset_detect (
        .clock(clock),
        .srst(srst),
        .req_level(reset_level_w),
        .monitored(cfg_monitored_reset),
        .accept(reset_accept)
    );

    // ----------------------------------------
    // category decoding
    // ----------------------------------------
    wire cat1_w = cfg_is_relay && (cfg_relay_cat == `SSOM_CAT_1);
    wire cat2_w = cfg_is_relay && (cfg_relay_cat == `SSOM_CAT_2);
    wire cat4_w = cfg_is_relay && (cfg_relay_cat == `SSOM_CAT_4);
    wire cat_ok_w = !cfg_is_relay || cat1_w || cat2_w || cat4_w;
    // cat 2 with manual restart and monitoring is not a legal setup
    wire cat2_mix_w = cat2_w && cfg_fbk_monitor && cfg_manual_restart;
    // cat 1 must not ask for contactor monitoring
    wire cat1_mon_w = cat1_w && cfg_fbk_monitor;
    wire cfg_bad_w = !present_w || !cat_ok_w || cat2_mix_w || cat1_mon_w;
    // effective monitoring: off in cat 1, forced on in cat 4
    wire mon_eff_w = cat4_w ? 1'b1 : (cat1_w ? 1'b0 : cfg_fbk_monitor);

    // ----------------------------------------
    // restart state machine
    // ----------------------------------------
    ssom_state_t state_reg;
    ssom_state_t state_next;
    logic fault_reg;
    logic fault_set_w;

    // off until input high, waits for reset when manual restart is chosen
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (block_in && !fault_reg && !cfg_bad_w) begin
                    state_next = cfg_manual_restart ? ST_WAIT_RESET : ST_ON;
                end
            end
            ST_WAIT_RESET: begin
                if (!block_in || fault_reg || cfg_bad_w) begin
                    state_next = ST_OFF;
                end else if (reset_accept) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                // a fall of the input always drops back, so with manual restart a new reset is needed
                if (!block_in || fault_reg || fault_set_w || cfg_bad_w) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    wire out_on_next = (state_next == ST_ON);
    logic out_on_reg;

    // ----------------------------------------
    // feedback window counter
    // ----------------------------------------
    ssom_ms_t ms_cnt_reg;
    wire out_change_w = (out_on_next != out_on_reg);
    wire ms_sat_w = (ms_cnt_reg == `SSOM_MS_MAX);

    // restarts at each output change, counts ms ticks, saturates
    always_ff @(posedge clock) begin
        if (srst) begin
            ms_cnt_reg <= `SSOM_RST_MS;
            out_on_reg <= `SSOM_RST_BIT;
        end else begin
            out_on_reg <= out_on_next;
            if (out_change_w) begin
                ms_cnt_reg <= `SSOM_RST_MS;
            end else if (ms_tick && !ms_sat_w) begin
                ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // feedback check
    // ----------------------------------------
    // contacts are normally closed: feedback is expected opposite to output
    wire fbk_expect_w = !out_on_reg;
    // relays are checked both ways, the semiconductor pair while on; without
    // monitoring the feedback must return high within the fixed idle window
    wire check_mon_w = mon_eff_w && (cfg_is_relay || out_on_reg);
    wire check_idle_w = !mon_eff_w && !cfg_fbk_unconnected && !out_on_reg;
    wire check_en_w = check_mon_w || check_idle_w;
    wire ssom_ms_t limit_w = mon_eff_w ? cfg_fbk_window_ms : `SSOM_IDLE_FBK_MS;
    // the count can run up to one tick ahead of real time, so only a count past the window is late
    wire late_w = ms_sat_w || (ms_cnt_reg > limit_w);
    assign fault_set_w = check_en_w && late_w && (fbk_w != fbk_expect_w);

    // fault latch, a new fault wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            fault_reg <= `SSOM_RST_BIT;
        end else if (fault_set_w) begin
            fault_reg <= 1'b1;
        end else if (global_reset_operator) begin
            fault_reg <= 1'b0;
        end
    end

    logic error_reg;

    // error output holds until power cycle or global reset, set wins
    always_ff @(posedge clock) begin
        if (srst) begin
            error_reg <= `SSOM_RST_BIT;
        end else if (fault_set_w && cfg_error_out_en) begin
            error_reg <= 1'b1;
        end else if (global_reset_operator) begin
            error_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // clear indicator lamp flashing
    // ----------------------------------------
    ssom_ms_t lamp_cnt_reg;
    logic lamp_reg;
    wire lamp_wrap_w = (lamp_cnt_reg == `SSOM_LAMP_HALF_MS - 16'h0001);

    // toggles every half period while a feedback fault is latched
    always_ff @(posedge clock) begin
        if (srst || !fault_reg) begin
            lamp_cnt_reg <= `SSOM_RST_MS;
            lamp_reg <= `SSOM_RST_BIT;
        end else if (ms_tick) begin
            lamp_cnt_reg <= lamp_wrap_w ? `SSOM_RST_MS : lamp_cnt_reg + 16'h0001;
            lamp_reg <= lamp_wrap_w ? !lamp_reg : lamp_reg;
        end
    end

    // ----------------------------------------
    // output drive decoding
    // ----------------------------------------
    // fault as it stands after this edge, so the test indicator drops with it
    wire fault_after_w = fault_set_w || (fault_reg && !global_reset_operator);
    wire semi_a_w = out_on_next && !cfg_is_relay;
    wire semi_b_w = out_on_next && !cfg_is_relay && double_w;
    wire relay_a_w = out_on_next && cfg_is_relay;
    wire relay_b_w = out_on_next && cat4_w;
    wire ote_w = cat2_w && !cfg_bad_w && !fault_after_w;
    wire status_w = cfg_status_en && out_on_next;
    wire expose_w = cfg_manual_restart || mon_eff_w;

    // every output leaves a flip-flop: channel drives first
    always_ff @(posedge clock) begin
        if (srst) begin
            output_channel_a <= `SSOM_RST_BIT;
            output_channel_b <= `SSOM_RST_BIT;
            relay_contact_a <= `SSOM_RST_BIT;
            relay_contact_b <= `SSOM_RST_BIT;
        end else begin
            output_channel_a <= semi_a_w;
            output_channel_b <= semi_b_w;
            relay_contact_a <= relay_a_w;
            relay_contact_b <= relay_b_w;
        end
    end

    // indicators that follow the block state, and the registered copy of low_int_in
    always_ff @(posedge clock) begin
        if (srst) begin
            output_test_indicator <= `SSOM_RST_BIT;
            status_out <= `SSOM_RST_BIT;
            low_int_status_out <= `SSOM_RST_BIT;
        end else begin
            output_test_indicator <= ote_w;
            status_out <= status_w;
            low_int_status_out <= low_int_in;
        end
    end

    // outputs decoded from the configuration alone
    always_ff @(posedge clock) begin
        if (srst) begin
            test_pulse_en <= `SSOM_RST_BIT;
            safety_lost <= `SSOM_RST_BIT;
            restart_feedback_exposed <= `SSOM_RST_BIT;
            config_fault <= `SSOM_RST_BIT;
        end else begin
            test_pulse_en <= !cfg_no_test_pulse && !cfg_is_relay;
            safety_lost <= cfg_no_test_pulse && !cfg_is_relay;
            restart_feedback_exposed <= expose_w;
            config_fault <= cfg_bad_w;
        end
    end

    assign error_out = error_reg;
    assign clear_indicator_lamp = lamp_reg;
endmodule

// ### sim/ssom_contactor.sv
// external contactor model with a normally closed feedback contact
`timescale 1ns/10ps
module ssom_contactor #(
    parameter int DELAY = 3
) (
    input wire logic clock,
    input wire logic coil,
    input wire logic stuck,
    output logic feedback_pin
);
    logic [DELAY-1:0] arm_reg = '0;
    // armature follows the coil a few cycles late
    always_ff @(posedge clock) begin
        arm_reg <= {arm_reg[DELAY-2:0], coil};
    end
    // nc contact closed while released; welded contact holds it closed
    assign feedback_pin = stuck | ~arm_reg[DELAY-1];
endmodule

// ### sim/ssom_top_sva.sv
// port assertions of the safety output monitor
`timescale 1ns/10ps
module ssom_top_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic block_in,
    input wire logic reset_pin,
    input wire logic low_int_in,
    input wire logic global_reset_operator,
    input wire logic cfg_manual_restart,
    input wire logic cfg_error_out_en,
    input wire logic cfg_no_test_pulse,
    input wire logic cfg_is_relay,
    input wire logic [1:0] cfg_relay_cat,
    input wire logic output_channel_a,
    input wire logic relay_contact_a,
    input wire logic relay_contact_b,
    input wire logic error_out,
    input wire logic test_pulse_en,
    input wire logic safety_lost,
    input wire logic low_int_status_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // ------------------------------
    // outputs and faults
    // ------------------------------
    property p_off;
        !block_in |=> !(output_channel_a || relay_contact_a);
    endproperty
    a_off: assert property (p_off) else $error("output on after input low");
    sequence s_fall;
        $fell(block_in) && cfg_manual_restart && !reset_pin;
    endsequence
    sequence s_no_press;
        (cfg_manual_restart && !reset_pin)[*8];
    endsequence
    property p_manual;
        (!reset_pin)[*4] ##1 s_fall ##1 s_no_press |-> !output_channel_a;
    endproperty
    a_manual: assert property (p_manual) else $error("restart without reset");
    property p_low_int;
        low_int_in |=> low_int_status_out;
    endproperty
    a_low_int: assert property (p_low_int) else $error("status output lag");
    property p_pair;
        (cfg_is_relay && cfg_relay_cat == 2'h3)[*3] |-> relay_contact_b == relay_contact_a;
    endproperty
    a_pair: assert property (p_pair) else $error("relay pair split");
    property p_err_hold;
        error_out && !global_reset_operator |=> error_out;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped");
    property p_err_en;
        $rose(error_out) |-> $past(cfg_error_out_en);
    endproperty
    a_err_en: assert property (p_err_en) else $error("error while disabled");
    property p_fault_off;
        $rose(error_out) |=> !output_channel_a && !relay_contact_a;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("on after fault");
    property p_no_pulse;
        (!cfg_is_relay && cfg_no_test_pulse)[*3] |-> safety_lost && !test_pulse_en;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("test pulse state");
endmodule

bind ssom_top ssom_top_sva i_ssom_top_sva (
    .clock, .srst, .block_in, .reset_pin, .low_int_in, .global_reset_operator,
    .cfg_manual_restart, .cfg_error_out_en, .cfg_no_test_pulse, .cfg_is_relay,
    .cfg_relay_cat, .output_channel_a, .relay_contact_a, .relay_contact_b, .error_out,
    .test_pulse_en, .safety_lost, .low_int_status_out
);

// ### sim/tb_ssom_top.sv
// self-checking bench of the safety output monitor
`timescale 1ns/10ps
module tb_ssom_top;
    localparam int MS = 4;
    logic clock, srst, block_in, reset_pin, feedback_pin, global_reset_operator, low_int_in;
    logic cfg_manual_restart, cfg_monitored_reset, cfg_fbk_monitor, cfg_error_out_en;
    logic cfg_status_en, cfg_no_test_pulse, cfg_fbk_unconnected, cfg_is_relay, stuck;
    logic [15:0] cfg_fbk_window_ms;
    logic [1:0] cfg_relay_cat, cfg_layout;
    logic output_channel_a, output_channel_b, relay_contact_a, relay_contact_b, error_out;
    logic clear_indicator_lamp, status_out, output_test_indicator, test_pulse_en, safety_lost;
    logic restart_feedback_exposed, low_int_status_out, config_fault;
    int err_count, num_checks;

    ssom_top #(.MS_CYCLES(MS)) i_ssom_top (
        .clock, .srst, .block_in, .reset_pin, .feedback_pin, .global_reset_operator, .low_int_in,
        .cfg_manual_restart, .cfg_monitored_reset, .cfg_fbk_monitor, .cfg_fbk_window_ms,
        .cfg_error_out_en, .cfg_status_en, .cfg_no_test_pulse, .cfg_fbk_unconnected,
        .cfg_is_relay, .cfg_relay_cat, .cfg_layout, .output_channel_a, .output_channel_b,
        .relay_contact_a, .relay_contact_b, .error_out, .clear_indicator_lamp, .status_out,
        .output_test_indicator, .test_pulse_en, .safety_lost, .restart_feedback_exposed,
        .low_int_status_out, .config_fault
    );
    ssom_contactor i_ssom_contactor (
        .clock, .coil(output_channel_a | relay_contact_a), .stuck, .feedback_pin
    );

    task automatic chk(input string what, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(negedge clock);
    endtask

    // quiet start: output off, contactor released, faults cleared
    task automatic setup(input logic rel, input logic [1:0] cat, input logic man, input logic mon);
        {block_in, reset_pin, stuck, cfg_monitored_reset, cfg_no_test_pulse} = 5'h00;
        {cfg_is_relay, cfg_relay_cat, cfg_manual_restart, cfg_fbk_monitor} = {rel, cat, man, mon};
        cfg_layout = 2'h0;
        cfg_error_out_en = 1'b1;
        tk(8);
        global_reset_operator = 1'b1;
        tk(1);
        global_reset_operator = 1'b0;
        tk(2);
    endtask

    // semiconductor channel a follows the block input, channel b stays off
    task automatic t_follow;
        setup(1'b0, 2'h1, 1'b0, 1'b0);
        block_in = 1'b1;
        low_int_in = 1'b1;
        tk(1);
        chk("low_int", low_int_status_out, 1'b1);
        tk(1);
        chk("chan_a", output_channel_a, 1'b1);
        chk("chan_b", output_channel_b, 1'b0);
        chk("status", status_out, 1'b1);
        chk("pulse", test_pulse_en, 1'b1);
        chk("relay", relay_contact_a, 1'b0);
        chk("rfb off", restart_feedback_exposed, 1'b0);
        block_in = 1'b0;
        low_int_in = 1'b0;
        tk(2);
        chk("chan_a off", output_channel_a, 1'b0);
        chk("status off", status_out, 1'b0);
        chk("low_int off", low_int_status_out, 1'b0);
        $display("follow done");
    endtask

    // channel layouts and the no test pulse option
    task automatic t_layout;
        setup(1'b0, 2'h1, 1'b0, 1'b0);
        cfg_layout = 2'h1;
        cfg_no_test_pulse = 1'b1;
        cfg_status_en = 1'b0;
        block_in = 1'b1;
        tk(3);
        chk("double", output_channel_b, 1'b1);
        chk("lost", safety_lost, 1'b1);
        chk("no pulse", test_pulse_en, 1'b0);
        chk("status masked", status_out, 1'b0);
        cfg_layout = 2'h2;
        tk(3);
        chk("mixed", output_channel_b, 1'b0);
        cfg_layout = 2'h3;
        tk(3);
        chk("bad layout", config_fault, 1'b1);
        cfg_status_en = 1'b1;
        $display("layout done");
    endtask

    // manual restart, rising edge and full pulse types
    task automatic t_restart;
        for (int m = 0; m < 2; m++) begin
            setup(1'b0, 2'h1, 1'b1, 1'b0);
            cfg_monitored_reset = m[0];
            block_in = 1'b1;
            tk(10);
            chk("wait", output_channel_a, 1'b0);
            chk("rfb", restart_feedback_exposed, 1'b1);
            reset_pin = 1'b1;
            tk(8);
            chk("rise", output_channel_a, m == 0);
            reset_pin = 1'b0;
            tk(8);
            chk("pulse", output_channel_a, 1'b1);
            block_in = 1'b0;
            tk(2);
            block_in = 1'b1;
            tk(10);
            chk("rearm", output_channel_a, 1'b0);
        end
        $display("restart done");
    endtask

    // feedback window, lamp, latch and clear
    task automatic t_fault;
        logic lit;
        lit = 1'b0;
        setup(1'b0, 2'h1, 1'b0, 1'b1);
        block_in = 1'b1;
        tk(12 * MS);
        chk("good on", output_channel_a, 1'b1);
        chk("good err", error_out, 1'b0);
        chk("lamp idle", clear_indicator_lamp, 1'b0);
        block_in = 1'b0;
        tk(8);
        stuck = 1'b1;
        block_in = 1'b1;
        tk(6 * MS);
        chk("fault off", output_channel_a, 1'b0);
        chk("fault err", error_out, 1'b1);
        repeat (1200) begin
            tk(1);
            lit = lit | clear_indicator_lamp;
        end
        chk("lamp", lit, 1'b1);
        stuck = 1'b0;
        tk(8);
        chk("held err", error_out, 1'b1);
        global_reset_operator = 1'b1;
        tk(1);
        global_reset_operator = 1'b0;
        tk(1);
        chk("err clear", error_out, 1'b0);
        tk(2);
        chk("back on", output_channel_a, 1'b1);
        cfg_error_out_en = 1'b0;
        stuck = 1'b1;
        tk(6 * MS);
        chk("err masked", error_out, 1'b0);
        $display("fault done");
    endtask

    // relay categories, pairing and test indicator
    task automatic t_relay;
        setup(1'b1, 2'h3, 1'b0, 1'b0);
        block_in = 1'b1;
        tk(3);
        chk("k4 a", relay_contact_a, 1'b1);
        chk("k4 b", relay_contact_b, 1'b1);
        chk("k4 ote", output_test_indicator, 1'b0);
        stuck = 1'b1;
        tk(6 * MS);
        chk("k4 forced", relay_contact_a, 1'b0);
        chk("k4 err", error_out, 1'b1);
        setup(1'b1, 2'h1, 1'b0, 1'b1);
        chk("k1 mon", config_fault, 1'b1);
        setup(1'b1, 2'h0, 1'b0, 1'b0);
        chk("no cat", config_fault, 1'b1);
        setup(1'b1, 2'h1, 1'b1, 1'b0);
        block_in = 1'b1;
        tk(8);
        chk("k1 wait", relay_contact_a, 1'b0);
        chk("k1 cfg", config_fault, 1'b0);
        setup(1'b1, 2'h2, 1'b1, 1'b1);
        chk("k2 mix", config_fault, 1'b1);
        setup(1'b1, 2'h2, 1'b0, 1'b1);
        block_in = 1'b1;
        tk(3);
        chk("k2 ote", output_test_indicator, 1'b1);
        stuck = 1'b1;
        tk(6 * MS);
        chk("k2 ote off", output_test_indicator, 1'b0);
        chk("k2 err", error_out, 1'b1);
        $display("relay done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // clock at 125 MHz
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // reset, then the tests in turn
    initial begin
        {srst, block_in, reset_pin, stuck, global_reset_operator, low_int_in} = 6'h20;
        {cfg_is_relay, cfg_relay_cat, cfg_manual_restart, cfg_fbk_monitor, cfg_layout} = 7'h10;
        {cfg_monitored_reset, cfg_no_test_pulse, cfg_fbk_unconnected} = 3'h0;
        {cfg_status_en, cfg_error_out_en} = 2'h3;
        cfg_fbk_window_ms = 16'h0003;
        err_count = 0;
        num_checks = 0;
        tk(8);
        srst = 1'b0;
        t_follow;
        t_layout;
        t_restart;
        t_fault;
        t_relay;
        wrap_up;
    end

    // hang guard, well past the planned run
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        wrap_up;
    end
endmodule
